// ---- include/asu_pkg.sv ----
// package: shared constants and carrier types for the serial uart
package asu_pkg;

  // ****************************************
  // framing constants
  // ****************************************
  localparam int ASU_DATA_BITS = 8;
  localparam int ASU_OVERSAMPLE = 16;
  localparam logic [3:0] ASU_MID_SAMPLE = 4'h7;
  localparam logic [3:0] ASU_LAST_TICK = 4'hf;
  localparam logic [15:0] ASU_DIV_RESET = 16'h0000;
  localparam logic [2:0] ASU_LAST_DATA_BIT = 3'h7;
  localparam int ASU_FIFO_DEPTH = 32;

  // ****************************************
  // multinode match schemes
  // ****************************************
  localparam logic [1:0] ASU_MATCH_NONE = 2'h0;
  localparam logic [1:0] ASU_MATCH_ALL_ADDR = 2'h1;
  localparam logic [1:0] ASU_MATCH_HW = 2'h2;
  localparam logic [1:0] ASU_MATCH_HW_DATA = 2'h3;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic parity_enable_bit;
    logic parity_odd;
    logic two_stop;
    logic flow_control_enable;
    logic multinode_enable;
    logic multinode_tx_flag;
    logic [1:0] multinode_match_scheme;
    logic irq_errors_only;
  } asu_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic framing_err;
    logic parity_err;
    logic brk;
    logic new_frame;
  } asu_rx_word_t;

  typedef enum logic [2:0] {
    ASU_IDLE = 3'b000,
    ASU_START = 3'b001,
    ASU_DATA = 3'b010,
    ASU_NINTH = 3'b011,
    ASU_STOP1 = 3'b100,
    ASU_STOP2 = 3'b101
  } asu_state_t;

endpackage

// ---- rtl/asu_fifo_mem.sv ----
// file: small dual-port memory with registered read data
`timescale 1ns/1ps
module asu_fifo_mem import asu_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ASU_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic mclk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // asu_fifo_mem

// ---- rtl/asu_fifo.sv ----
// file: first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module asu_fifo import asu_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ASU_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ****************************************
  // pointers
  // ****************************************
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count;
  logic out_valid_reg, out_valid_next;
  logic push, pop, load;
  logic [AW-1:0] rd_addr;

  // one word sits in the output register; its slot stays reserved so it cannot be overwritten
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = (count != (AW+1)'(DEPTH - 1));
  assign push = in_valid && in_ready;
  assign load = (count != '0) && (!out_valid_reg || out_ready);
  assign pop = load;
  assign out_valid = out_valid_reg;
  // without a pop, re-read the shown word so the output stays steady
  assign rd_addr = load ? rd_ptr_reg[AW-1:0] : rd_ptr_reg[AW-1:0] - AW'(1);

  always_comb begin
    wr_ptr_next = wr_ptr_reg + (AW+1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
    out_valid_next = out_valid_reg;
    if (load) begin
      out_valid_next = 1'b1;
    end else if (out_ready) begin
      out_valid_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      out_valid_reg <= out_valid_next;
    end
  end

  asu_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .mclk(mclk),
    .wr_en(push),
    .wr_addr(wr_ptr_reg[AW-1:0]),
    .wr_data(in_data),
    .rd_addr(rd_addr),
    .rd_data(out_data)
  );
endmodule // asu_fifo

// ---- rtl/asu_uart.sv ----
// file: full-duplex serial uart with clear-to-send flow control
// Contract
// - eight data bits, least significant first
// - parity appended and checked, even or odd
// - one low start, one or two stops
// - holding empty flag shows free register; here the flag reads low during reset
// - held byte moves to shifter automatically
// - transmit only while enabled
// - receive only while enabled
// - ninth bit follows multinode transmit flag
// - multinode enable selects nine-bit framing
// - transmit interrupt while holding register empty and transmit enabled
// - receive available flag shows held byte
// - receive interrupt on data, errors, break
// - interrupt on data and errors, or errors
// - two-bit field picks address scheme
// - address bytes compared with node address
// - flow control only when enabled
// - clear-to-send sampled before each character
// - character in flight always finishes
// - ninth bit between data and stops
// - holding write clears empty flag
`timescale 1ns/1ps
module asu_uart import asu_pkg::*; #(
  parameter int FIFO_DEPTH = ASU_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration
  input wire asu_cfg_t cfg,
  input wire logic [7:0] baud_div_hi,
  input wire logic [7:0] baud_div_lo,
  input wire logic [7:0] node_address,
  // transmit holding register
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  output logic tx_holding_empty,
  output logic tx_irq,
  // receive data
  output logic rx_data_available,
  output asu_rx_word_t rx_word,
  input wire logic rx_read,
  output logic rx_irq,
  // serial pins
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rxd_sync_reg, rxd_sync_next, cts_sync_reg, cts_sync_next;
  logic rxd_s, cts_s;
  always_comb begin
    rxd_sync_next = {rxd_sync_reg[0], rxd};
    cts_sync_next = {cts_sync_reg[0], cts_n};
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rxd_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h3;
    end else begin
      rxd_sync_reg <= rxd_sync_next;
      cts_sync_reg <= cts_sync_next;
    end
  end
  assign rxd_s = rxd_sync_reg[1];
  assign cts_s = cts_sync_reg[1];

  // ****************************************
  // baud generator, sixteen ticks per bit
  // ****************************************
  logic [15:0] baud_cnt_reg, baud_cnt_next;
  logic tick_reg, tick_next;
  always_comb begin
    tick_next = 1'b0;
    baud_cnt_next = baud_cnt_reg - 16'h0001;
    if (baud_cnt_reg == ASU_DIV_RESET) begin
      baud_cnt_next = {baud_div_hi, baud_div_lo};
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      baud_cnt_reg <= ASU_DIV_RESET;
      tick_reg <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  asu_state_t tx_state_reg, tx_state_next;
  logic [7:0] hold_reg, hold_next, tx_shift_reg, tx_shift_next;
  logic hold_full_reg, hold_full_next, txd_reg, txd_next, tx_ninth_reg, tx_ninth_next;
  logic [3:0] tx_tick_reg, tx_tick_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic tx_irq_reg, tx_irq_next;
  logic empty_reg, empty_next;
  logic tx_bit_end, tx_clear;

  assign tx_bit_end = tick_reg && (tx_tick_reg == ASU_LAST_TICK);
  // low level lets the next character go
  assign tx_clear = !cfg.flow_control_enable || !cts_s;

  always_comb begin
    tx_state_next = tx_state_reg;
    hold_next = hold_reg;
    hold_full_next = hold_full_reg;
    tx_shift_next = tx_shift_reg;
    tx_ninth_next = tx_ninth_reg;
    txd_next = txd_reg;
    tx_bit_next = tx_bit_reg;
    tx_tick_next = tick_reg ? tx_tick_reg + 4'h1 : tx_tick_reg;
    if (tx_write) begin
      hold_next = tx_data;
      hold_full_next = 1'b1;
    end
    unique case (tx_state_reg)
      ASU_IDLE: begin
        txd_next = 1'b1;
        tx_tick_next = '0;
        // load shifter when enabled and clear
        if (hold_full_reg && cfg.tx_enable_bit && tx_clear) begin
          tx_shift_next = hold_reg;
          // ninth bit is flag or parity
          tx_ninth_next = cfg.multinode_enable ? cfg.multinode_tx_flag
                                               : (^hold_reg) ^ cfg.parity_odd;
          hold_full_next = tx_write;
          tx_bit_next = '0;
          txd_next = 1'b0;
          tx_state_next = ASU_START;
        end
      end
      ASU_START: begin
        if (tx_bit_end) begin
          txd_next = tx_shift_reg[0];
          tx_state_next = ASU_DATA;
        end
      end
      ASU_DATA: begin
        if (tx_bit_end) begin
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_bit_next = tx_bit_reg + 3'h1;
          txd_next = tx_shift_reg[1];
          if (tx_bit_reg == ASU_LAST_DATA_BIT) begin
            if (cfg.multinode_enable || cfg.parity_enable_bit) begin
              txd_next = tx_ninth_reg;
              tx_state_next = ASU_NINTH;
            end else begin
              txd_next = 1'b1;
              tx_state_next = ASU_STOP1;
            end
          end
        end
      end
      ASU_NINTH: begin
        if (tx_bit_end) begin
          txd_next = 1'b1;
          tx_state_next = ASU_STOP1;
        end
      end
      ASU_STOP1: begin
        if (tx_bit_end) begin
          tx_state_next = cfg.two_stop ? ASU_STOP2 : ASU_IDLE;
        end
      end
      ASU_STOP2: begin
        if (tx_bit_end) begin
          tx_state_next = ASU_IDLE;
        end
      end
      default: tx_state_next = ASU_IDLE;
    endcase
    empty_next = !hold_full_next;
    tx_irq_next = empty_next && cfg.tx_enable_bit;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_state_reg <= ASU_IDLE;
      hold_reg <= '0;
      hold_full_reg <= 1'b0;
      tx_shift_reg <= '0;
      tx_ninth_reg <= 1'b0;
      txd_reg <= 1'b1;
      tx_bit_reg <= '0;
      tx_tick_reg <= '0;
      tx_irq_reg <= 1'b0;
      empty_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      hold_reg <= hold_next;
      hold_full_reg <= hold_full_next;
      tx_shift_reg <= tx_shift_next;
      tx_ninth_reg <= tx_ninth_next;
      txd_reg <= txd_next;
      tx_bit_reg <= tx_bit_next;
      tx_tick_reg <= tx_tick_next;
      tx_irq_reg <= tx_irq_next;
      empty_reg <= empty_next;
    end
  end
  assign txd = txd_reg;
  // flag is inverse of holding full outside reset; reset clears both
  assign tx_holding_empty = empty_reg;
  assign tx_irq = tx_irq_reg;

  // ****************************************
  // receiver
  // ****************************************
  asu_state_t rx_state_reg, rx_state_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic [3:0] rx_tick_reg, rx_tick_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic rx_ninth_reg, rx_ninth_next;
  logic matched_reg, matched_next, first_reg, first_next;
  logic rx_mid, push_valid, push_ready;
  asu_rx_word_t push_word;

  assign rx_mid = tick_reg && (rx_tick_reg == ASU_MID_SAMPLE);

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_bit_next = rx_bit_reg;
    rx_ninth_next = rx_ninth_reg;
    matched_next = matched_reg;
    first_next = first_reg;
    rx_tick_next = tick_reg ? rx_tick_reg + 4'h1 : rx_tick_reg;
    push_valid = 1'b0;
    push_word = '0;
    unique case (rx_state_reg)
      ASU_IDLE: begin
        rx_tick_next = '0;
        if (cfg.rx_enable_bit && !rxd_s) begin
          rx_state_next = ASU_START;
        end
      end
      ASU_START: begin
        if (rx_mid) begin
          rx_bit_next = '0;
          rx_state_next = rxd_s ? ASU_IDLE : ASU_DATA;
        end
      end
      ASU_DATA: begin
        if (rx_mid) begin
          rx_shift_next = {rxd_s, rx_shift_reg[7:1]};
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == ASU_LAST_DATA_BIT) begin
            rx_state_next = (cfg.multinode_enable || cfg.parity_enable_bit)
                            ? ASU_NINTH : ASU_STOP1;
          end
        end
      end
      ASU_NINTH: begin
        if (rx_mid) begin
          rx_ninth_next = rxd_s;
          rx_state_next = ASU_STOP1;
        end
      end
      ASU_STOP1: begin
        // only the first stop is checked; a second stop reads as idle line
        if (rx_mid) begin
          rx_state_next = ASU_IDLE;
          push_word.data = rx_shift_reg;
          push_word.ninth = rx_ninth_reg && cfg.multinode_enable;
          push_word.framing_err = !rxd_s;
          push_word.parity_err = cfg.parity_enable_bit && !cfg.multinode_enable
                                 && ((^rx_shift_reg) ^ rx_ninth_reg ^ cfg.parity_odd);
          push_word.brk = !rxd_s && (rx_shift_reg == 8'h00) && !rx_ninth_reg;
          push_word.new_frame = 1'b0;
          push_valid = 1'b1;
          if (cfg.multinode_enable && rx_ninth_reg) begin
            matched_next = (rx_shift_reg == node_address);
            first_next = 1'b1;
            unique case (cfg.multinode_match_scheme)
              ASU_MATCH_NONE: push_valid = 1'b1;
              ASU_MATCH_ALL_ADDR: push_valid = 1'b1;
              ASU_MATCH_HW: push_valid = (rx_shift_reg == node_address);
              ASU_MATCH_HW_DATA: push_valid = 1'b0;
            endcase
          end else if (cfg.multinode_enable) begin
            unique case (cfg.multinode_match_scheme)
              ASU_MATCH_NONE: push_valid = 1'b1;
              ASU_MATCH_ALL_ADDR: push_valid = 1'b0;
              ASU_MATCH_HW: push_valid = matched_reg;
              ASU_MATCH_HW_DATA: push_valid = matched_reg;
            endcase
            push_word.new_frame = first_reg && push_valid;
            if (push_valid) begin
              first_next = 1'b0;
            end
          end
        end
      end
      default: rx_state_next = ASU_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_state_reg <= ASU_IDLE;
      rx_shift_reg <= '0;
      rx_tick_reg <= '0;
      rx_bit_reg <= '0;
      rx_ninth_reg <= 1'b0;
      matched_reg <= 1'b0;
      first_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_tick_reg <= rx_tick_next;
      rx_bit_reg <= rx_bit_next;
      rx_ninth_reg <= rx_ninth_next;
      matched_reg <= matched_next;
      first_reg <= first_next;
    end
  end

  // ****************************************
  // receive buffer and status outputs
  // ****************************************
  // a full buffer drops the frame; overrun flagging is left out
  logic fifo_valid;
  asu_rx_word_t fifo_word;
  asu_fifo #(.WIDTH($bits(asu_rx_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(fifo_valid),
    .out_ready(rx_read),
    .out_data(fifo_word)
  );

  logic rda_reg, rda_next, rx_irq_reg, rx_irq_next;
  asu_rx_word_t word_reg, word_next;
  logic word_err;
  always_comb begin
    rda_next = fifo_valid && !rx_read;
    word_next = fifo_word;
    word_err = fifo_word.framing_err || fifo_word.parity_err || fifo_word.brk;
    // data and errors, or errors only
    rx_irq_next = rda_next && (word_err || !cfg.irq_errors_only);
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rda_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      rda_reg <= rda_next;
      rx_irq_reg <= rx_irq_next;
      word_reg <= word_next;
    end
  end
  assign rx_data_available = rda_reg;
  assign rx_word = word_reg;
  assign rx_irq = rx_irq_reg;
endmodule // asu_uart

// ---- testbench/asu_remote.sv ----
// partner: remote serial node driving rxd and cts_n, sampling txd
`timescale 1ns/1ps
module asu_remote #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic mclk,
  // serial lines
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  // bit length follows the divisor under test
  int bit_cyc = BIT_CYC;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic bwait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // low lets the next start, raised well before it
  task automatic set_cts(input logic v);
    cts_n = v;
  endtask
  // low start, lsb first, stop of chosen level, then a spare idle bit
  task automatic send(input logic [8:0] v, input int nb, input logic stp);
    rxd = 1'b0;
    bwait(bit_cyc);
    for (int i = 0; i < nb; i++) begin
      rxd = v[i];
      bwait(bit_cyc);
    end
    rxd = stp;
    bwait(bit_cyc);
    rxd = 1'b1;
    bwait(bit_cyc);
  endtask
  // bounded hunt for a start, then mid-bit sampling
  task automatic recv(input int nb, input int stops, output logic [8:0] v, output logic ok);
    int n;
    v = '0;
    n = 0;
    while (txd !== 1'b0 && n < 400) begin
      bwait(1);
      n++;
    end
    ok = (n < 400);
    if (ok) begin
      bwait(bit_cyc / 2);
      ok = (txd === 1'b0);
      for (int i = 0; i < nb; i++) begin
        bwait(bit_cyc);
        v[i] = txd;
      end
      for (int i = 0; i < stops; i++) begin
        bwait(bit_cyc);
        ok = ok && (txd === 1'b1);
      end
    end
  endtask
endmodule // asu_remote

// ---- testbench/asu_uart_asserts.sv ----
// checker: port-level assertions for the serial uart
`timescale 1ns/1ps
module asu_uart_checker import asu_pkg::*; #(
  parameter int FIFO_DEPTH = ASU_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // control side
  input wire asu_cfg_t cfg,
  input wire logic tx_write,
  input wire logic tx_holding_empty,
  input wire logic tx_irq,
  input wire logic rx_data_available,
  input wire asu_rx_word_t rx_word,
  input wire logic rx_read,
  input wire logic rx_irq,
  // serial pins
  input wire logic cts_n,
  input wire logic txd
);
  logic [2:0] up_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // masks the rise of the empty flag that follows reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  idle_reset_a: assert property (!$past(reset_n) |-> txd)
    else $error("txd not idle after reset");
  empty_fall_a: assert property (tx_write |=> !tx_holding_empty)
    else $error("empty flag kept after write");
  tx_irq_on_a: assert property (tx_holding_empty && cfg.tx_enable_bit
    && $stable({tx_holding_empty, cfg}) |-> tx_irq) else $error("tx irq missing");
  tx_irq_off_a: assert property (!tx_holding_empty && $stable(tx_holding_empty) |-> !tx_irq)
    else $error("tx irq while full");
  load_start_a: assert property (up_reg == 3'h7 && $rose(tx_holding_empty)
    |-> !txd && cfg.tx_enable_bit) else $error("load without start bit");
  cts_stall_a: assert property ((cfg.flow_control_enable && cts_n)[*6]
    |=> !$rose(tx_holding_empty)) else $error("start while clear-to-send high");
  avail_hold_a: assert property (rx_data_available && !rx_read |=> rx_data_available)
    else $error("receive flag dropped unread");
  word_hold_a: assert property (rx_data_available && !rx_read |=> $stable(rx_word))
    else $error("receive word changed unread");
  read_clear_a: assert property (rx_read && rx_data_available |=> !rx_data_available)
    else $error("receive flag kept after read");
  data_irq_a: assert property (rx_data_available && !cfg.irq_errors_only
    && $stable({rx_data_available, cfg}) |-> rx_irq) else $error("rx irq missing");
  err_only_a: assert property (rx_data_available && cfg.irq_errors_only
    && !rx_word.parity_err && !rx_word.framing_err && $stable({rx_data_available, cfg})
    |-> !rx_irq) else $error("rx irq on clean data");
  cover property (tx_write && !tx_holding_empty);
  cover property (cfg.flow_control_enable && cts_n && txd);
  cover property (rx_read && rx_data_available && rx_irq);
endmodule // asu_uart_checker
bind asu_uart asu_uart_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .cfg(cfg), .tx_write(tx_write), .tx_holding_empty(tx_holding_empty), .tx_irq(tx_irq),
  .rx_data_available(rx_data_available), .rx_word(rx_word), .rx_read(rx_read),
  .rx_irq(rx_irq), .cts_n(cts_n), .txd(txd));

// ---- testbench/async_serial_uart_with_cts_test.sv ----
// testbench: self-checking bench for the serial uart
`timescale 1ns/1ps
module async_serial_uart_with_cts_test import asu_pkg::*;;
  logic mclk;
  logic reset_n;
  asu_cfg_t cfg;
  logic [7:0] node_address;
  logic [7:0] baud_div_hi;
  logic [7:0] baud_div_lo;
  logic tx_write;
  logic [7:0] tx_data;
  logic rx_read;
  logic rxd;
  logic cts_n;
  logic txd;
  logic tx_holding_empty;
  logic tx_irq;
  logic rx_data_available;
  logic rx_irq;
  asu_rx_word_t rx_word;
  int bad_count;
  int cmp_count;
  // divisor mostly zero: sixteen clocks a bit keeps the run short
  asu_uart u_asu_uart (.mclk(mclk), .reset_n(reset_n), .cfg(cfg),
    .baud_div_hi(baud_div_hi), .baud_div_lo(baud_div_lo), .node_address(node_address),
    .tx_write(tx_write), .tx_data(tx_data),
    .tx_holding_empty(tx_holding_empty), .tx_irq(tx_irq), .rx_data_available(rx_data_available),
    .rx_word(rx_word), .rx_read(rx_read), .rx_irq(rx_irq), .rxd(rxd), .cts_n(cts_n), .txd(txd));
  asu_remote u_asu_remote (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic write_tx(input logic [7:0] d);
    tx_data = d;
    tx_write = 1'b1;
    tick(1);
    tx_write = 1'b0;
    check("empty flag", tx_holding_empty, 1'b0);
  endtask
  task automatic expect_tx(input logic [8:0] exp, input int nb, input int stops);
    logic [8:0] v;
    logic ok;
    u_asu_remote.recv(nb, stops, v, ok);
    check("tx frame", v, exp);
    check("tx framing", ok, 1'b1);
    if (ok !== 1'b1) tally_and_finish();
  endtask
  task automatic hold_idle(input int n);
    repeat (n) begin
      tick(1);
      check("txd held", txd, 1'b1);
    end
  endtask
  task automatic read_rx(input logic [7:0] d);
    check("rx avail", rx_data_available, 1'b1);
    check("rx data", rx_word.data, d);
    rx_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
    check("rx drained", rx_data_available, 1'b0);
    tick(3);
  endtask
  task automatic t_tx_formats();
    logic [12:0] tbl [5];
    logic [7:0] d;
    logic par;
    tbl = '{13'h00a5, 13'h143c, 13'h1881, 13'h0355, 13'h06ff};
    for (int i = 0; i < 5; i++) begin
      {cfg.parity_enable_bit, cfg.parity_odd, cfg.two_stop, cfg.multinode_enable,
        cfg.multinode_tx_flag} = tbl[i][12:8];
      d = tbl[i][7:0];
      par = cfg.parity_enable_bit & (cfg.parity_odd ^ (^d));
      write_tx(d);
      expect_tx({cfg.multinode_enable ? cfg.multinode_tx_flag : par, d},
        (cfg.parity_enable_bit || cfg.multinode_enable) ? 9 : 8, cfg.two_stop ? 2 : 1);
    end
    cfg = '0;
    cfg.tx_enable_bit = 1'b1;
    cfg.rx_enable_bit = 1'b1;
  endtask
  task automatic t_tx_gate();
    cfg.tx_enable_bit = 1'b0;
    tick(2);
    check("irq disabled", tx_irq, 1'b0);
    write_tx(8'h5a);
    hold_idle(40);
    cfg.tx_enable_bit = 1'b1;
    expect_tx(9'h05a, 8, 1);
    write_tx(8'hc3);
    // c3 waits out the stop bit of the frame before it
    tick(10);
    check("empty at start", tx_holding_empty, 1'b1);
    write_tx(8'h3c);
    expect_tx(9'h0c3, 8, 1);
    expect_tx(9'h03c, 8, 1);
    cfg.flow_control_enable = 1'b1;
    u_asu_remote.set_cts(1'b1);
    tick(4);
    write_tx(8'h81);
    hold_idle(40);
    u_asu_remote.set_cts(1'b0);
    expect_tx(9'h081, 8, 1);
    write_tx(8'h42);
    fork
      expect_tx(9'h042, 8, 1);
      begin
        tick(40);
        u_asu_remote.set_cts(1'b1);
      end
    join
    write_tx(8'h24);
    hold_idle(30);
    // flow control off: clear-to-send is ignored
    cfg.flow_control_enable = 1'b0;
    expect_tx(9'h024, 8, 1);
    u_asu_remote.set_cts(1'b0);
  endtask
  task automatic t_baud();
    baud_div_lo = 8'h01;
    u_asu_remote.bit_cyc = 32;
    tick(40);
    write_tx(8'h96);
    expect_tx(9'h096, 8, 1);
    baud_div_lo = 8'h00;
    u_asu_remote.bit_cyc = 16;
  endtask
  task automatic t_rx_basic();
    cfg.rx_enable_bit = 1'b0;
    u_asu_remote.send(9'h011, 8, 1'b1);
    tick(4);
    check("rx off", rx_data_available, 1'b0);
    cfg.rx_enable_bit = 1'b1;
    u_asu_remote.send(9'h03c, 8, 1'b1);
    tick(4);
    check("data irq", rx_irq, 1'b1);
    read_rx(8'h3c);
    cfg.parity_enable_bit = 1'b1;
    cfg.parity_odd = 1'b1;
    cfg.irq_errors_only = 1'b1;
    u_asu_remote.send(9'h13c, 9, 1'b1);
    tick(4);
    check("parity ok", rx_word.parity_err, 1'b0);
    check("no data irq", rx_irq, 1'b0);
    read_rx(8'h3c);
    u_asu_remote.send(9'h03c, 9, 1'b1);
    tick(4);
    check("parity bad", rx_word.parity_err, 1'b1);
    check("error irq", rx_irq, 1'b1);
    read_rx(8'h3c);
    cfg.parity_enable_bit = 1'b0;
    cfg.irq_errors_only = 1'b0;
    u_asu_remote.send(9'h000, 8, 1'b0);
    tick(4);
    check("break", {rx_word.brk, rx_word.framing_err}, 2'h3);
    read_rx(8'h00);
  endtask
  task automatic t_rx_multi();
    logic [12:0] tbl [10];
    logic [12:0] e;
    // scheme, ninth, byte, word expected, new frame expected
    tbl = '{13'h1418, 13'h11dc, 13'h1416, 13'h1267, 13'h126a, 13'h1c14, 13'h184b, 13'h0cce,
      13'h0910, 13'h0156};
    cfg.multinode_enable = 1'b1;
    for (int i = 0; i < 10; i++) begin
      e = tbl[i];
      cfg.multinode_match_scheme = e[12:11];
      u_asu_remote.send({e[10], e[9:2]}, 9, 1'b1);
      tick(4);
      check("node filter", rx_data_available, e[1]);
      if (e[1] && !e[10] && e[12]) check("new frame", rx_word.new_frame, e[0]);
      if (rx_data_available === 1'b1) begin
        check("ninth", rx_word.ninth, e[10]);
        read_rx(e[9:2]);
      end
    end
    cfg.multinode_enable = 1'b0;
  endtask
  task automatic t_fifo();
    for (int i = 0; i <= ASU_FIFO_DEPTH; i++) begin
      u_asu_remote.send({1'b0, 8'(i)}, 8, 1'b1);
    end
    tick(4);
    for (int i = 0; i < ASU_FIFO_DEPTH; i++) begin
      read_rx(8'(i));
    end
    // the frame beyond a full buffer is lost
    check("overflow lost", rx_data_available, 1'b0);
  endtask
  initial begin
    bad_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    tx_write = 1'b0;
    tx_data = 8'h00;
    rx_read = 1'b0;
    node_address = 8'h05;
    baud_div_hi = 8'h00;
    baud_div_lo = 8'h00;
    cfg = '0;
    cfg.tx_enable_bit = 1'b1;
    cfg.rx_enable_bit = 1'b1;
    tick(4);
    reset_n = 1'b1;
    check("idle txd", txd, 1'b1);
    tick(3);
    check("empty after reset", tx_holding_empty, 1'b1);
    check("irq at once", tx_irq, 1'b1);
    check("rx empty", rx_data_available, 1'b0);
    t_tx_formats();
    t_tx_gate();
    t_baud();
    t_rx_basic();
    t_rx_multi();
    t_fifo();
    tally_and_finish();
  end
endmodule // async_serial_uart_with_cts_test
